// ===== common/ord_defines.svh
`ifndef ORD_DEFINES_SVH
`define ORD_DEFINES_SVH
// Register addresses
`define ORD_ADDR_STATUS 8'h10
`define ORD_ADDR_CFG 8'h11
`define ORD_ADDR_DEBOUNCE 8'h12
`define ORD_ADDR_TILT 8'h13
`define ORD_ADDR_TRIP 8'h14
// Reset values
`define ORD_RST_DEBOUNCE 8'h00
`define ORD_RST_TILT 8'h84
`define ORD_RST_TRIP 8'h44
`define ORD_RST_CFG 8'h80
// Field positions
`define ORD_CFG_DBMODE 7
`define ORD_CFG_ENABLE 6
// Lock limit: 1.25 g in 14-bit counts at 4096 counts per g
`define ORD_LOCK_LIMIT 14'h1400
`endif

// ===== common/ord_pkg.sv
package ord_pkg;
    // Orientation codes as reported
    typedef enum logic [1:0] {
        ORD_PORTRAIT_UP = 2'h0,
        ORD_PORTRAIT_DOWN = 2'h1,
        ORD_LANDSCAPE_RIGHT = 2'h2,
        ORD_LANDSCAPE_LEFT = 2'h3
    } ord_orient_t;
    // Oversampling modes
    typedef enum logic [1:0] {
        ORD_MODE_NORMAL = 2'h0,
        ORD_MODE_LNLP = 2'h1,
        ORD_MODE_HIRES = 2'h2,
        ORD_MODE_LOWPWR = 2'h3
    } ord_mode_t;
endpackage

// ===== rtl/ord_detect.sv
`include "ord_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module ord_detect
    import ord_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic sample_tick,
    input wire logic signed [13:0] accel_x,
    input wire logic signed [13:0] accel_y,
    input wire logic signed [13:0] accel_z,
    input wire logic [2:0] odr_select,
    input wire logic [1:0] oversample_mode,
    input wire logic hybrid_mode,
    input wire logic device_active,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic orientation_changed
);
    ////////////////////////////////////////////////////////////////
    // Registers
    logic [7:0] debounce_count_q; // Debounce target
    logic [7:0] tilt_angles_q; // Back/front and Z-lock
    logic [7:0] trip_q; // Threshold and hysteresis
    logic [7:0] cfg_q; // Mode and enable
    logic [2:0] odr_q; // Last ODR for change detect
    logic active_q; // Last active state
    logic hyb_q; // Hybrid second-sample skip
    logic [7:0] cnt_q; // Debounce counter
    logic [2:0] cand_q; // Candidate {orientation, back}
    logic changed_q; // Change flag
    logic tilt_tripped_q; // Z-tilt lockout state
    logic [1:0] orient_q; // Reported orientation
    logic back_q; // Reported back facing
    logic first_q; // First detection pending

    ////////////////////////////////////////////////////////////////
    // Register writes
    // writable debounce count, tilt angles, trip and config
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            debounce_count_q <= `ORD_RST_DEBOUNCE;
            // z-lock reset 4, back/front reset 0b10
            tilt_angles_q <= `ORD_RST_TILT;
            // threshold reset 8, hysteresis reset 4
            trip_q <= `ORD_RST_TRIP;
            cfg_q <= `ORD_RST_CFG;
        end else if (reg_wr) begin
            if (reg_addr == `ORD_ADDR_DEBOUNCE) begin
                debounce_count_q <= reg_wdata;
            end else if (reg_addr == `ORD_ADDR_TILT) begin
                tilt_angles_q <= {reg_wdata[7:6], 3'h0, reg_wdata[2:0]};
            end else if (reg_addr == `ORD_ADDR_TRIP) begin
                trip_q <= reg_wdata;
            end else if (reg_addr == `ORD_ADDR_CFG) begin
                cfg_q <= {reg_wdata[7:6], 6'h00};
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // Angle arithmetic on magnitudes
    logic [13:0] ax, ay, az, ahoriz;
    logic [21:0] tan_scaled, cot_scaled, z_lim, bf_lim;
    logic [4:0] trip_eff;
    logic lock_over, z_low, to_front, to_back;
    logic [1:0] pl_raw;

    // Z-lock tangent table, scaled by 64
    function automatic logic [7:0] zlock_tan(input logic [2:0] c);
        case (c)
            3'h0: zlock_tan = 8'h11;
            3'h1: zlock_tan = 8'h15;
            3'h2: zlock_tan = 8'h1a;
            3'h3: zlock_tan = 8'h1e;
            3'h4: zlock_tan = 8'h23;
            3'h5: zlock_tan = 8'h28;
            3'h6: zlock_tan = 8'h2e;
            default: zlock_tan = 8'h36;
        endcase
    endfunction

    // Back/front cotangent of 80/75/70/65 deg, scaled by 64
    function automatic logic [7:0] bf_tan(input logic [1:0] c);
        case (c)
            2'h0: bf_tan = 8'h0b;
            2'h1: bf_tan = 8'h11;
            2'h2: bf_tan = 8'h17;
            default: bf_tan = 8'h1e;
        endcase
    endfunction

    // Hysteresis offset added or removed from threshold code
    function automatic logic [4:0] hys_off(input logic [2:0] h);
        hys_off = {1'b0, h, 1'b0} - {2'h0, h[2:1], 1'b0} + {4'h0, h[2]};
    endfunction

    always_comb begin
        ax = accel_x[13] ? 14'(-accel_x) : accel_x;
        ay = accel_y[13] ? 14'(-accel_y) : accel_y;
        az = accel_z[13] ? 14'(-accel_z) : accel_z;
        ahoriz = (ax > ay) ? ax : ay;
        // lock when any axis above 1.25 g
        lock_over = (ax > `ORD_LOCK_LIMIT) || (ay > `ORD_LOCK_LIMIT) ||
                    (az > `ORD_LOCK_LIMIT);
        // tilt lockout if horizontal small vs Z
        z_lim = 22'(az) * 22'(zlock_tan(tilt_angles_q[2:0]));
        z_low = ({2'h0, ahoriz, 6'h00} < z_lim);
        // back/front windows from Z sign and angle
        bf_lim = 22'(ahoriz) * 22'(bf_tan(tilt_angles_q[7:6]));
        to_front = !accel_z[13] && ({2'h0, az, 6'h00} > bf_lim);
        to_back = accel_z[13] && ({2'h0, az, 6'h00} > bf_lim);
        // hysteresis narrows the current state's side
        trip_eff = (orient_q[1])
            ? 5'(trip_q[7:3] + hys_off(trip_q[2:0]))
            : 5'(trip_q[7:3] - hys_off(trip_q[2:0]));
        // threshold code scaled against |x| vs |y|
        tan_scaled = 22'(ay) * 22'(trip_eff);
        cot_scaled = {2'h0, ax, 6'h00} >> 2;
        if (cot_scaled > tan_scaled) begin
            pl_raw = accel_x[13] ? ORD_LANDSCAPE_LEFT : ORD_LANDSCAPE_RIGHT;
        end else begin
            // Y near -1 g is portrait up, near +1 g portrait down
            pl_raw = accel_y[13] ? ORD_PORTRAIT_UP : ORD_PORTRAIT_DOWN;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Effective sample tick
    logic eval;
    // hybrid mode uses every second sample
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            hyb_q <= 1'b0;
        end else if (sample_tick) begin
            hyb_q <= hybrid_mode ? !hyb_q : 1'b0;
        end
    end
    assign eval = sample_tick && (!hybrid_mode || hyb_q) &&
                  cfg_q[`ORD_CFG_ENABLE] && device_active;

    ////////////////////////////////////////////////////////////////
    // Debounce and state commit
    logic [2:0] cand;
    logic new_state, restart;
    assign cand = {pl_raw, to_back ? 1'b1 : (to_front ? 1'b0 : back_q)};
    assign new_state = cand != {orient_q, back_q};
    // restart on ODR change or active toggle
    assign restart = (odr_select != odr_q) || (device_active != active_q);

    // Track ODR and activity
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            odr_q <= 3'h0;
            active_q <= 1'b0;
        end else begin
            odr_q <= odr_select;
            active_q <= device_active;
        end
    end

    // Debounce counter; step length follows the effective tick
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cnt_q <= 8'h00;
            cand_q <= 3'h0;
        end else if (restart) begin
            cnt_q <= 8'h00;
        end else if (eval) begin
            if (lock_over || z_low || !(new_state || first_q)) begin
                // clear or decrement when condition lost
                if (cfg_q[`ORD_CFG_DBMODE] || cnt_q == 8'h00) begin
                    cnt_q <= 8'h00;
                end else begin
                    cnt_q <= cnt_q - 8'h01;
                end
            end else if (cand != cand_q) begin
                cand_q <= cand;
                cnt_q <= 8'h01;
            end else if (cnt_q < debounce_count_q) begin
                cnt_q <= cnt_q + 8'h01;
            end
        end
    end

    // Reported state
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            orient_q <= ORD_PORTRAIT_UP;
            back_q <= 1'b0;
            tilt_tripped_q <= 1'b0;
        end else if (eval && !restart && !lock_over) begin
            tilt_tripped_q <= z_low;
            if (!z_low && cand == cand_q && cnt_q >= debounce_count_q) begin
                orient_q <= cand[2:1];
                back_q <= cand[0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // Change flag
    logic commit_event;
    assign commit_event = eval && !restart && !lock_over &&
        ((z_low != tilt_tripped_q) ||
         (!z_low && cand == cand_q && cnt_q >= debounce_count_q &&
          (new_state || first_q)));
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            changed_q <= 1'b0;
            first_q <= 1'b1;
        end else begin
            if (device_active && !active_q) begin
                first_q <= 1'b1;
            end else if (commit_event) begin
                first_q <= 1'b0;
            end
            if (commit_event) begin
                changed_q <= 1'b1;
            end else if (reg_rd && reg_addr == `ORD_ADDR_STATUS) begin
                changed_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // Read data register
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            if (reg_addr == `ORD_ADDR_STATUS) begin
                reg_rdata <= {changed_q, tilt_tripped_q, 3'h0, orient_q,
                              back_q};
            end else if (reg_addr == `ORD_ADDR_CFG) begin
                reg_rdata <= cfg_q;
            end else if (reg_addr == `ORD_ADDR_DEBOUNCE) begin
                reg_rdata <= debounce_count_q;
            end else if (reg_addr == `ORD_ADDR_TILT) begin
                reg_rdata <= tilt_angles_q;
            end else if (reg_addr == `ORD_ADDR_TRIP) begin
                reg_rdata <= trip_q;
            end else begin
                reg_rdata <= 8'h00;
            end
        end
    end

    assign orientation_changed = changed_q;
    wire logic unused_ok = &{1'b0, oversample_mode};
endmodule
`default_nettype wire

// ===== dv/ord_detect_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module ord_detect_chk (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic sample_tick,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic orientation_changed
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    // Status read strobe
    logic st_rd;
    assign st_rd = reg_rd && reg_addr == 8'h10;
    // Write, then a read of the same place
    sequence wr_rd(a);
        reg_wr && reg_addr == a ##1 !reg_wr ##1
            reg_rd && !reg_wr && reg_addr == a;
    endsequence
    property wr_rd_p(a, m);
        wr_rd(a) |=> (reg_rdata & m) == ($past(reg_wdata, 3) & m);
    endproperty
    a_count_readback: assert property (wr_rd_p(8'h12, 8'hff))
        else $error("debounce count readback wrong");
    a_tilt_readback: assert property (wr_rd_p(8'h13, 8'hc7))
        else $error("tilt angle readback wrong");
    a_trip_readback: assert property (wr_rd_p(8'h14, 8'hff))
        else $error("trip threshold readback wrong");
    a_flag_echo: assert property (
        st_rd |=> reg_rdata[7] == $past(orientation_changed))
        else $error("status flag bit differs from flag");
    a_flag_hold: assert property (
        orientation_changed && !st_rd |=> orientation_changed)
        else $error("flag dropped without a status read");
    a_flag_from_tick: assert property (
        $rose(orientation_changed) |-> $past(sample_tick)
        || $past(sample_tick, 2) || $past(sample_tick, 3))
        else $error("flag rose with no sample");
    a_unmapped_zero: assert property (reg_rd && (reg_addr < 8'h10
        || reg_addr > 8'h14) |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved without a read");
endmodule
bind ord_detect ord_detect_chk u_chk (.sys_clk(sys_clk), .rstn(rstn),
    .sample_tick(sample_tick), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .orientation_changed(orientation_changed));
`default_nettype wire

// ===== dv/ord_detect_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ord_detect_tb
    import ord_pkg::*;
;
    localparam logic signed [13:0] G = 14'h0fa0;
    logic sys_clk, rstn, sample_tick, hybrid_mode, device_active;
    logic reg_wr, reg_rd, pend, chg;
    logic signed [13:0] ax, ay, az, zv;
    logic [1:0] osm;
    logic signed [13:0] tx[4], ty[4];
    logic [2:0] odr;
    logic [7:0] addr, wdata, rdata, d;
    logic [7:0] aq[$], eq[$], mq[$];
    int error_cnt, checked, seed, cyc, k, p;
    ord_detect DUT (.sys_clk(sys_clk), .rstn(rstn),
        .sample_tick(sample_tick), .accel_x(ax), .accel_y(ay),
        .accel_z(az), .odr_select(odr), .oversample_mode(osm),
        .hybrid_mode(hybrid_mode), .device_active(device_active),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(addr),
        .reg_wdata(wdata), .reg_rdata(rdata), .orientation_changed(chg));
    // Clock at 4 ns
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    // Expected status byte
    function automatic logic [7:0] st(input logic f, input int o);
        return {f, 4'h0, 2'(o), 1'b0};
    endfunction
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        reg_wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        @(posedge sys_clk);
    endtask
    // Read with expected value noted
    task automatic rd(input logic [7:0] a, e, m);
        aq.push_back(a);
        eq.push_back(e & m);
        mq.push_back(m);
        reg_rd <= 1'b1;
        addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(posedge sys_clk);
    endtask
    // Samples with small noise, one tick in four cycles
    task automatic smp(input logic signed [13:0] x, y, input int n);
        repeat (n) begin
            sample_tick <= 1'b1;
            ax <= x + 14'($random(seed) % 64);
            ay <= y + 14'($random(seed) % 64);
            az <= zv + 14'($random(seed) % 64);
            @(posedge sys_clk);
            sample_tick <= 1'b0;
            repeat (3) @(posedge sys_clk);
        end
    endtask
    task automatic results();
        $display("checked %0d error_cnt %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Read data monitor
    always @(posedge sys_clk) pend <= reg_rd;
    always @(negedge sys_clk) begin
        if (pend && eq.size() > 0) begin
            checked++;
            if ((rdata & mq[0]) !== eq[0]) begin
                error_cnt++;
                $display("[FAIL] reg %h exp %h got %h", aq[0], eq[0],
                    rdata & mq[0]);
            end
            // Status read leaves the flag output clear
            if (aq[0] == 8'h10) begin
                checked++;
                if (chg !== 1'b0) begin
                    error_cnt++;
                    $display("[FAIL] flag after read exp 0 got %b", chg);
                end
            end
            void'(aq.pop_front());
            void'(eq.pop_front());
            void'(mq.pop_front());
        end
    end
    // Hang guard
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            results();
        end
    end
    initial begin
        seed = 32'h3e62_334e;
        osm = 2'($random(seed));
        zv = 14'h0320;
        {rstn, sample_tick, reg_wr, reg_rd, hybrid_mode} = 5'h00;
        device_active = 1'b0;
        {ax, ay, az} = 42'h0;
        {odr, addr, wdata} = 19'h0_0000;
        tx = '{14'h0000, 14'h0000, G, -G};
        ty = '{-G, G, 14'h0000, 14'h0000};
        repeat (12) @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
        rd(8'h11, 8'h80, 8'hc0);
        rd(8'h12, 8'h00, 8'hff);
        rd(8'h13, 8'h84, 8'hc7);
        rd(8'h14, 8'h44, 8'hff);
        rd(8'h20, 8'h00, 8'hff);
        rd(8'h0f, 8'h00, 8'hff);
        for (int i = 0; i < 4; i++) begin
            d = 8'($random(seed));
            wr(8'h14, d);
            rd(8'h14, d, 8'hff);
            wr(8'h13, d);
            rd(8'h13, d, 8'hc7);
        end
        wr(8'h13, 8'h84);
        wr(8'h14, 8'h44);
        wr(8'h12, 8'h03);
        rd(8'h12, 8'h03, 8'hff);
        wr(8'h11, 8'hc0);
        device_active <= 1'b1;
        $display("done: registers");
        p = 0;
        for (int i = 0; i < 4; i++) begin
            k = (i == 0) ? 2 : (i == 1) ? 1 : (i == 2) ? 3 : 0;
            smp(tx[k], ty[k], 1);
            rd(8'h10, st(1'b0, p), i == 0 ? 8'h80 : 8'hc6);
            smp(tx[k], ty[k], 4);
            rd(8'h10, st(1'b1, k), 8'hc6);
            rd(8'h10, 8'h00, 8'h80);
            p = k;
        end
        $display("done: orientations");
        smp(14'h1450, 14'h0000, 6);
        rd(8'h10, st(1'b0, 0), 8'hc6);
        smp(G, 14'h0000, 2);
        odr <= 3'h3;
        smp(G, 14'h0000, 2);
        rd(8'h10, st(1'b0, 0), 8'hc6);
        smp(G, 14'h0000, 4);
        rd(8'h10, st(1'b1, 2), 8'hc6);
        smp(-G, 14'h0000, 2);
        device_active <= 1'b0;
        @(posedge sys_clk);
        device_active <= 1'b1;
        smp(-G, 14'h0000, 2);
        rd(8'h10, st(1'b0, 2), 8'hc6);
        smp(-G, 14'h0000, 4);
        rd(8'h10, st(1'b1, 3), 8'hc6);
        $display("done: lock and clears");
        hybrid_mode <= 1'b1;
        smp(14'h0000, -G, 4);
        rd(8'h10, st(1'b0, 3), 8'hc6);
        smp(14'h0000, -G, 4);
        rd(8'h10, st(1'b1, 0), 8'hc6);
        hybrid_mode <= 1'b0;
        wr(8'h11, 8'h80);
        smp(14'h0000, G, 6);
        rd(8'h10, st(1'b0, 0), 8'hc6);
        // Flat device: Z dominates, tilt lockout trips
        wr(8'h11, 8'hc0);
        zv = G;
        smp(14'h0000, 14'h0000, 1);
        rd(8'h10, 8'hc0, 8'hc6);
        $display("done: hybrid, enable and z-lock");
        results();
    end
endmodule
`default_nettype wire
